// ==== verilog/serial_port_frame_control.v ====
// Contract
// - unexpected sync drops partial shift contents
// - unexpected sync sets sync error flag
// - offending sync starts a new frame
// - ignore set: unexpected sync has no effect
// - data delay code gives 0/1/2 bit cycles
// - single phase frame is count1+1 words
// - dual phase frame adds count2+1 words
// - transmit control one field layout kept
// - reserved bits read zero, fields reset zero
// - transmit one or two phases selectable
// - per-phase transmit word length and count
// - transmit companding select held, none allowed
// - transmit sync ignore control held
// - transmit first bit delay held
// - sync before frame complete is unexpected
// - word length codes 8..32 bits, 6/7 reserved
`timescale 1ns/1ps
`include "serial_frame_defs.vh"

////////////////////////////////////////////////////////////////////////////
// operation notes
//
// clocking
// - everything runs on clk_sys_in; the bit clock, frame sync and data
//   pins are treated as asynchronous and pass two flip-flops each
// - all three pins share the same synchroniser depth, so a sync and the
//   data bit launched with it are seen at the same system clock edge
// - a bit-clock rising edge is found by comparing the second stage with
//   its previous value; the bit clock must stay high and low for at least
//   two system clocks each or edges are lost
// - the bit clock may stop between frames; nothing times out while it
//   stands still, the engine simply waits for the next edge
//
// frame sync
// - a sync is a low to high change of the sync pin seen at a bit-clock
//   rising edge; a sync held high over several bit edges counts once
// - the previous sync level only advances on bit edges, so a short glitch
//   between bit edges is never seen as a sync
// - a sync while the engine is not idle is unexpected
// - with ignore cleared an unexpected sync drops the partial word, raises
//   the error flag and restarts the frame at that very edge
// - with ignore set an unexpected sync changes nothing at all
//
// data delay
// - code 0: the bit present at the sync edge is the first data bit
// - code 1: the first data bit follows one bit edge after the sync edge
// - code 2: the first data bit follows two bit edges after the sync edge
// - code 3 is reserved; the first data bit follows three bit edges after the sync edge and
//   software must not use it
//
// words and frames
// - words arrive msb first and are handed over right aligned
// - word length codes 0..5 select 8, 12, 16, 20, 24 and 32 bits; the
//   reserved codes 6 and 7 fall back to 8 bits
// - phase one holds count1 + 1 words; with dual phase a second phase of
//   count2 + 1 words follows with its own word length
// - words inside a frame are back to back: the bit edge after a word's
//   last bit carries the first bit of the next word
// - each finished word gives a one-cycle valid pulse; the word output
//   holds until the next word replaces it
//
// register bus
// - every request sees exactly one wait state; the answer stands in the
//   second cycle of the request, which keeps the read mux off the path
//   of the bus address
// - read data is registered at the first cycle of a read and holds until
//   the next read, so a slow master sees a stable value
// - only the low 16 bits carry the control registers; the upper half of
//   a control register read is zero
// - unmapped addresses read zero and ignore writes
//
// flags and interrupts
// - the sync error flag in the port control register and the three
//   status bits are cleared by writing a one
// - an event in the same cycle as its clear wins, so no event is lost
//   to a clear that software meant for an older one
// - the interrupt output is a plain level of status and mask; it needs no
//   extra register because both terms already come from flip-flops
//
// transmit side
// - the two transmit control registers are storage only in this block;
//   phase select, word counts and lengths, companding, sync ignore and
//   data delay are kept for the transmit engine that reads them
// - reserved bits of the first transmit register never store and so
//   always read zero
//
// limitations
// - received words are not buffered: a word not read before the next one
//   completes is overwritten
// - clearing the enable bit stops reception at once and drops any frame
//   in progress without raising an error
// - companded receive data is not expanded here
////////////////////////////////////////////////////////////////////////////


module serial_port_frame_control (
  input  wire        clk_sys_in,
  input  wire        sys_rst_in,
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  input  wire        rx_bit_clock_in,
  input  wire        receive_frame_sync_in,
  input  wire        rx_data_in,
  output wire        irq_out,
  output reg  [31:0] rx_word_out,
  output reg         rx_word_valid_out,
  output reg         rx_frame_active_out
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [15:0] serial_port_control_one;
  reg [15:0] receive_frame_control_one;
  reg [15:0] receive_frame_control_two;
  reg [15:0] transmit_frame_control_one;
  reg [15:0] transmit_frame_control_two;
  reg [2:0]  irq_status;
  reg [2:0]  irq_mask;
  reg        ack;

  wire        rx_enable                = serial_port_control_one[`SPC_RX_ENABLE_BIT];
  wire        rx_dual_phase_select     = receive_frame_control_two[`RX_PHASE_BIT];
  wire [6:0]  rx_phase_one_word_count  = receive_frame_control_one[14:8];
  wire [2:0]  rx_phase_one_word_length = receive_frame_control_one[7:5];
  wire [6:0]  rx_phase_two_word_count  = receive_frame_control_two[`RX_COUNT_MSB:`RX_COUNT_LSB];
  wire [2:0]  rx_phase_two_word_length = receive_frame_control_two[`RX_LEN_MSB:`RX_LEN_LSB];
  wire        rx_unexpected_sync_ignore = receive_frame_control_two[`RX_IGNORE_BIT];
  wire [1:0]  rx_first_bit_delay       = receive_frame_control_two[`RX_DELAY_MSB:`RX_DELAY_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage is read only by the second
  reg [1:0] clk_sync;
  reg [1:0] fs_sync;
  reg [1:0] dat_sync;
  reg       clk_prev;
  reg       fs_prev;

  // sample on the rising bit-clock edge; a sync is its rising level at that edge
  wire bit_edge  = clk_sync[1] & ~clk_prev;
  wire sync_seen = bit_edge & fs_sync[1] & ~fs_prev;

  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      clk_sync <= 2'h0;
      fs_sync  <= 2'h0;
      dat_sync <= 2'h0;
      clk_prev <= 1'b0;
      fs_prev  <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[0], rx_bit_clock_in};
      fs_sync  <= {fs_sync[0], receive_frame_sync_in};
      dat_sync <= {dat_sync[0], rx_data_in};
      clk_prev <= clk_sync[1];
      if (bit_edge)
        fs_prev <= fs_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive frame engine
  localparam ST_IDLE  = 2'h0;
  localparam ST_DELAY = 2'h1;
  localparam ST_SHIFT = 2'h2;

  reg [1:0]  state;
  reg [1:0]  delay_left;
  reg [5:0]  bits_left;
  reg [6:0]  words_left;
  reg        in_phase_two;
  reg [31:0] receive_shift_register;
  reg        sync_error_event;
  reg        frame_done_event;

  // word length code to bits; reserved codes fall back to 8 bits
  function [5:0] len_bits;
    input [2:0] code;
    begin
      case (code)
        3'h0: len_bits = 6'd8;
        3'h1: len_bits = 6'd12;
        3'h2: len_bits = 6'd16;
        3'h3: len_bits = 6'd20;
        3'h4: len_bits = 6'd24;
        3'h5: len_bits = 6'd32;
        default: len_bits = 6'd8;
      endcase
    end
  endfunction

  wire [5:0] len_one = len_bits(rx_phase_one_word_length);
  wire [5:0] len_two = len_bits(rx_phase_two_word_length);

  // a sync while a frame is still being received is unexpected
  wire busy       = (state != ST_IDLE);
  wire unexpected = sync_seen & busy;
  wire accept     = sync_seen & (~busy | ~rx_unexpected_sync_ignore);
  wire last_bit   = (bits_left == 6'd1);
  wire last_word  = (words_left == 7'd0) & (in_phase_two | ~rx_dual_phase_select);

  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state                  <= ST_IDLE;
      delay_left             <= 2'h0;
      bits_left              <= 6'h0;
      words_left             <= 7'h0;
      in_phase_two           <= 1'b0;
      receive_shift_register <= 32'h0;
      rx_word_out            <= 32'h0;
      rx_word_valid_out      <= 1'b0;
      rx_frame_active_out    <= 1'b0;
      sync_error_event       <= 1'b0;
      frame_done_event       <= 1'b0;
    end else begin
      rx_word_valid_out <= 1'b0;
      sync_error_event  <= 1'b0;
      frame_done_event  <= 1'b0;
      if (!rx_enable) begin
        state               <= ST_IDLE;
        rx_frame_active_out <= 1'b0;
      end else if (accept) begin
        // drop partial word and restart framing on this sync
        receive_shift_register <= 32'h0;
        sync_error_event       <= unexpected;
        words_left             <= rx_phase_one_word_count;
        in_phase_two           <= 1'b0;
        bits_left              <= len_one;
        rx_frame_active_out    <= 1'b1;
        if (rx_first_bit_delay == 2'h0) begin
          // zero delay: the bit at the sync edge is the first bit
          state                  <= ST_SHIFT;
          receive_shift_register <= {31'h0, dat_sync[1]};
          bits_left              <= len_one - 6'd1;
        end else begin
          state      <= ST_DELAY;
          delay_left <= rx_first_bit_delay - 2'h1;
        end
      end else if (bit_edge) begin
        case (state)
          ST_IDLE: ;
          ST_DELAY: begin
            if (delay_left == 2'h0) begin
              state                  <= ST_SHIFT;
              receive_shift_register <= {31'h0, dat_sync[1]};
              bits_left              <= bits_left - 6'd1;
            end else begin
              delay_left <= delay_left - 2'h1;
            end
          end
          ST_SHIFT: begin
            if (bits_left == 6'd0) begin
              // first bit of a following word
              receive_shift_register <= {31'h0, dat_sync[1]};
              bits_left              <= (in_phase_two ? len_two : len_one) - 6'd1;
            end else begin
              receive_shift_register <= {receive_shift_register[30:0], dat_sync[1]};
              bits_left              <= bits_left - 6'd1;
              if (last_bit) begin
                rx_word_out       <= {receive_shift_register[30:0], dat_sync[1]};
                rx_word_valid_out <= 1'b1;
                if (last_word) begin
                  state               <= ST_IDLE;
                  rx_frame_active_out <= 1'b0;
                  frame_done_event    <= 1'b1;
                end else if (words_left == 7'd0) begin
                  // phase one done, dual phase adds count2+1 words
                  in_phase_two <= 1'b1;
                  words_left   <= rx_phase_two_word_count;
                  bits_left    <= 6'd0;
                end else begin
                  words_left <= words_left - 7'd1;
                end
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer on the second
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
  wire wr = avs_write_in & ack;

  function [15:0] merge;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  be;
    input [15:0] mask;
    begin
      merge = old;
      if (be[0]) merge[7:0]  = d[7:0];
      if (be[1]) merge[15:8] = d[15:8];
      merge = merge & mask;
    end
  endfunction

  wire [2:0] events = {frame_done_event, rx_word_valid_out, sync_error_event};

  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack                        <= 1'b0;
      serial_port_control_one    <= 16'h0;
      receive_frame_control_one  <= 16'h0;
      receive_frame_control_two  <= 16'h0;
      transmit_frame_control_one <= 16'h0;
      transmit_frame_control_two <= 16'h0;
      irq_status                 <= 3'h0;
      irq_mask                   <= 3'h0;
      avs_readdata_out           <= 32'h0;
    end else begin
      ack <= (avs_read_in | avs_write_in) & ~ack;
      // error flag: set wins over a write-one clear
      if (wr && avs_address_in == {1'b0, `REG_SERIAL_PORT_CONTROL_ONE} && avs_byteenable_in[0]) begin
        serial_port_control_one[`SPC_RX_ENABLE_BIT] <= avs_writedata_in[`SPC_RX_ENABLE_BIT];
        if (avs_writedata_in[`SPC_SYNC_ERROR_BIT])
          serial_port_control_one[`SPC_SYNC_ERROR_BIT] <= 1'b0;
      end
      if (sync_error_event)
        serial_port_control_one[`SPC_SYNC_ERROR_BIT] <= 1'b1;
      if (wr && avs_address_in == {1'b0, `REG_RECEIVE_FRAME_CONTROL_ONE})
        receive_frame_control_one <= merge(receive_frame_control_one, avs_writedata_in,
                                           avs_byteenable_in, `RCR1_WRITE_MASK);
      if (wr && avs_address_in == {1'b0, `REG_RECEIVE_FRAME_CONTROL_TWO})
        receive_frame_control_two <= merge(receive_frame_control_two, avs_writedata_in,
                                           avs_byteenable_in, 16'hffff);
      // reserved bits 15 and 4..0 never store
      if (wr && avs_address_in == {1'b0, `REG_TRANSMIT_FRAME_CONTROL_ONE})
        transmit_frame_control_one <= merge(transmit_frame_control_one, avs_writedata_in,
                                            avs_byteenable_in, `TRANSMIT_FRAME_CONTROL_ONE_WRITE_MASK);
      // phase, phase-two fields, companding, ignore and delay
      if (wr && avs_address_in == `REG_TRANSMIT_FRAME_CONTROL_TWO)
        transmit_frame_control_two <= merge(transmit_frame_control_two, avs_writedata_in,
                                            avs_byteenable_in, `TRANSMIT_FRAME_CONTROL_TWO_WRITE_MASK);
      if (wr && avs_address_in == `REG_IRQ_MASK && avs_byteenable_in[0])
        irq_mask <= avs_writedata_in[2:0];
      if (wr && avs_address_in == `REG_IRQ_STATUS && avs_byteenable_in[0])
        irq_status <= (irq_status & ~avs_writedata_in[2:0]) | events;
      else
        irq_status <= irq_status | events;
      // read mux; unmapped reads zero; captured once per read so the data stands
      if (avs_read_in && !ack)
      case (avs_address_in)
        {1'b0, `REG_SERIAL_PORT_CONTROL_ONE}:    avs_readdata_out <= {16'h0, serial_port_control_one};
        {1'b0, `REG_RECEIVE_FRAME_CONTROL_ONE}:  avs_readdata_out <= {16'h0, receive_frame_control_one};
        {1'b0, `REG_RECEIVE_FRAME_CONTROL_TWO}:  avs_readdata_out <= {16'h0, receive_frame_control_two};
        {1'b0, `REG_TRANSMIT_FRAME_CONTROL_ONE}: avs_readdata_out <= {16'h0, transmit_frame_control_one};
        `REG_TRANSMIT_FRAME_CONTROL_TWO:        avs_readdata_out <= {16'h0, transmit_frame_control_two};
        `REG_IRQ_STATUS:                        avs_readdata_out <= {29'h0, irq_status};
        `REG_IRQ_MASK:                          avs_readdata_out <= {29'h0, irq_mask};
        `REG_RX_DATA:                           avs_readdata_out <= rx_word_out;
        default:                                avs_readdata_out <= 32'h0;
      endcase
    end
  end

  // level interrupt while any unmasked status bit is set
  assign irq_out = |(irq_status & irq_mask);

endmodule // serial_port_frame_control

// ==== verilog/serial_frame_defs.vh ====
`ifndef SERIAL_FRAME_DEFS_VH
`define SERIAL_FRAME_DEFS_VH

// register byte offsets
`define REG_SERIAL_PORT_CONTROL_ONE 4'h0
`define REG_RECEIVE_FRAME_CONTROL_ONE 4'h4
`define REG_RECEIVE_FRAME_CONTROL_TWO 4'h8
`define REG_TRANSMIT_FRAME_CONTROL_ONE 4'hc

`define REG_TRANSMIT_FRAME_CONTROL_TWO 5'h10
`define REG_IRQ_STATUS 5'h14
`define REG_IRQ_MASK 5'h18
`define REG_RX_DATA 5'h1c

// serial_port_control_one fields
`define SPC_RX_ENABLE_BIT 0
`define SPC_SYNC_ERROR_BIT 3

// receive_frame_control_two fields
`define RX_PHASE_BIT 15
`define RX_COUNT_MSB 14
`define RX_COUNT_LSB 8
`define RX_LEN_MSB 7
`define RX_LEN_LSB 5
`define RX_IGNORE_BIT 2
`define RX_DELAY_MSB 1
`define RX_DELAY_LSB 0

// writable masks
`define TRANSMIT_FRAME_CONTROL_ONE_WRITE_MASK 16'h7fe0
`define RCR1_WRITE_MASK 16'h7fe0
`define RECEIVE_FRAME_CONTROL_TWO_WRITE_MASK 16'hfffb
`define TRANSMIT_FRAME_CONTROL_TWO_WRITE_MASK 16'hffff

// interrupt status bits
`define IRQ_SYNC_ERROR_BIT 0
`define IRQ_WORD_READY_BIT 1
`define IRQ_FRAME_DONE_BIT 2

`endif

// ==== testbench/serial_port_frame_control_props.sv ====
`timescale 1ns/1ps
module serial_port_frame_control_props (
  input logic        clk_sys_in,
  input logic        sys_rst_in,
  input logic [4:0]  avs_address_in,
  input logic        avs_read_in,
  input logic        avs_write_in,
  input logic [31:0] avs_readdata_out,
  input logic        avs_waitrequest_out,
  input logic        receive_frame_sync_in,
  input logic        irq_out,
  input logic [31:0] rx_word_out,
  input logic        rx_word_valid_out,
  input logic        rx_frame_active_out
);
  logic       req_prev;
  logic [3:0] fs_age;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////
  // request history and cycles since the sync pin was last high (saturates)
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      req_prev <= 1'b0;
      fs_age   <= 4'hf;
    end else begin
      req_prev <= avs_read_in || avs_write_in;
      fs_age   <= receive_frame_sync_in ? 4'h0 : fs_age + {3'h0, fs_age != 4'hf};
    end
  end
  // a fresh request sees exactly one wait state
  sequence s_fresh_req;
    (avs_read_in || avs_write_in) && !req_prev;
  endsequence
  sequence s_one_wait;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  chk_one_wait_state: assert property (s_fresh_req |-> s_one_wait) else $error("wait state count wrong");
  chk_idle_no_wait: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("waitrequest without request");
  chk_read_data_held: assert property ($changed(avs_readdata_out) |-> avs_read_in && !avs_waitrequest_out)
    else $error("read data moved outside a read");
  chk_upper_half_zero: assert property (
    avs_read_in && !avs_waitrequest_out && avs_address_in != 5'h1c |-> avs_readdata_out[31:16] == 16'h0)
    else $error("upper half not zero");
  chk_valid_one_cycle: assert property (rx_word_valid_out |=> !rx_word_valid_out) else $error("valid too long");
  chk_word_with_valid: assert property ($changed(rx_word_out) |-> rx_word_valid_out)
    else $error("word changed without valid");
  chk_frame_needs_sync: assert property ($rose(rx_frame_active_out) |-> fs_age < 4'h6)
    else $error("frame began without sync");
  chk_irq_drop_write: assert property ($fell(irq_out) |-> $past(avs_write_in)) else $error("irq fell without write");
endmodule // serial_port_frame_control_props
bind serial_port_frame_control serial_port_frame_control_props u_props (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .receive_frame_sync_in(receive_frame_sync_in), .irq_out(irq_out),
  .rx_word_out(rx_word_out), .rx_word_valid_out(rx_word_valid_out), .rx_frame_active_out(rx_frame_active_out));

// ==== testbench/serial_codec_model.sv ====
`timescale 1ns/1ps
// external framed codec; its bit clock stands low between frames
module serial_codec_model (
  output logic bit_clk_out,
  output logic frame_sync_out,
  output logic data_out
);
  initial begin
    bit_clk_out = 1'b0;
    frame_sync_out = 1'b0;
    data_out = 1'b0;
  end
  // words MSB first after dly edges; cut stops early, stray raises an extra sync
  task automatic frame(input int dly, input int nw, input int wl, input logic [31:0] w, input int cut,
                       input int stray);
    logic b;
    b = data_out;
    for (int k = 0; k < dly + nw * wl && k != cut; k++) begin
      b = (k >= dly) ? w[wl - 1 - (k - dly) % wl] : ~b;
      frame_sync_out = (k == 0 || k == stray);
      data_out = b;
      #40 bit_clk_out = 1'b1;
      #40 bit_clk_out = 1'b0;
    end
    frame_sync_out = 1'b0;
    data_out = ~data_out;  // released line must not keep showing the last bit
  endtask
endmodule // serial_codec_model

// ==== testbench/serial_port_frame_control_tb.sv ====
`timescale 1ns/1ps
module serial_port_frame_control_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  adr = 5'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, word, q;
  logic        wq, irq, valid, active, bck, fs, sd;
  int          fails = 0;
  int          compares = 0;
  int          wl_tab[6] = '{8, 12, 16, 20, 24, 32};
  logic [31:0] got[$];
  ////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  serial_codec_model u_codec (.bit_clk_out(bck), .frame_sync_out(fs), .data_out(sd));
  serial_port_frame_control u_dut (
    .clk_sys_in(clk), .sys_rst_in(rst), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(4'h3), .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
    .rx_bit_clock_in(bck), .receive_frame_sync_in(fs), .rx_data_in(sd), .irq_out(irq), .rx_word_out(word),
    .rx_word_valid_out(valid), .rx_frame_active_out(active));
  // words are caught mid-cycle, away from the edge that launches them
  always @(negedge clk) if (valid === 1'b1) got.push_back(word);
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // waitrequest and read data are taken at the rising edge; an idle cycle follows
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(q, e);
  endtask
  task automatic settle(input int n);
    int k;
    k = 0;
    while (got.size() < n && k < 400) begin
      @(posedge clk);
      k++;
    end
    repeat (8) @(posedge clk);
  endtask
  task wrap_up;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(5'h0c, 32'h0);
    rchk(5'h1e, 32'h0);
    bus(1'b1, 5'h0c, 32'hffff_ffff);
    rchk(5'h0c, 32'h7fe0);
    bus(1'b1, 5'h10, 32'hffff_ffff);
    rchk(5'h10, 32'hffff);
    $display("test registers done");
    bus(1'b1, 5'h00, 32'h1);
    for (int c = 0; c < 6; c++) begin
      bus(1'b1, 5'h04, 32'(c << 5));
      bus(1'b1, 5'h08, 32'(c % 3)); // delay code 3 is never written
      u_codec.frame(c % 3, 1, wl_tab[c], 32'hc3a5_96e1, -1, -1);
      settle(c + 1);
      cmp(got[c], 32'(32'hc3a5_96e1 & ((33'h1 << wl_tab[c]) - 33'h1)));
    end
    $display("test delay and length done");
    got.delete();
    bus(1'b1, 5'h04, 32'h0200);
    bus(1'b1, 5'h08, 32'h0301);  // phase two count must be ignored
    u_codec.frame(1, 3, 8, 32'h5a, -1, -1);
    settle(3);
    cmp(32'(got.size()), 32'h3);
    cmp({31'h0, active}, 32'h0);
    got.delete();
    bus(1'b1, 5'h08, 32'h8101);
    u_codec.frame(1, 5, 8, 32'h5a, 36, -1);  // stops three bits into the fifth word
    settle(4);
    cmp({31'h0, active}, 32'h1);
    u_codec.frame(1, 5, 8, 32'ha5, -1, -1);
    settle(9);
    cmp(32'(got.size()), 32'h9);
    cmp(got[4], 32'ha5);
    cmp({31'h0, active}, 32'h0);
    rchk(5'h00, 32'h9);
    cmp({31'h0, irq}, 32'h0);
    bus(1'b1, 5'h18, 32'h1);
    cmp({31'h0, irq}, 32'h1);
    bus(1'b1, 5'h14, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    bus(1'b1, 5'h00, 32'h9);
    $display("test frame abort done");
    got.delete();
    bus(1'b1, 5'h04, 32'h0040);
    bus(1'b1, 5'h08, 32'h0006);
    u_codec.frame(2, 1, 16, 32'h1234, -1, 7);
    settle(1);
    cmp(32'(got.size()), 32'h1);
    cmp(got[0], 32'h1234);
    rchk(5'h14, 32'h6);
    $display("test sync ignore done");
    wrap_up();
  end
endmodule // serial_port_frame_control_tb
